// >>> logic/gcc_map.svh
// Constants of the gated cycle counter: widths, limits and timing.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef GCC_MAP_SVH
`define GCC_MAP_SVH

// ==========================================
// Widths and limits
`define GCC_PIN_NUM       16          // General-purpose pins
`define GCC_SEL_W         4           // Pin selector width, 0 to 15
`define GCC_CNT_W         16          // Accumulator and duration width
`define GCC_DEST_W        8           // Result destination tag width
`define GCC_CNT_MAX       16'hFFFF    // Saturation value, also longest window
`define GCC_CNT_ONE       16'h0001    // Increment step
`define GCC_CNT_ZERO      16'h0000    // Cleared accumulator
`define GCC_PIN_ZERO      16'h0000    // All pins inputs after reset

// ==========================================
// Timing
`define GCC_CLK_PERIOD_NS 10          // System clock period in ns
`define GCC_UNIT_US       1000        // Window time unit in us (slow variant)
`define GCC_UNIT_CYC      ((`GCC_UNIT_US * 1000) / `GCC_CLK_PERIOD_NS)

`endif

// >>> logic/gcc_pkg.sv
// Types shared by the gated cycle counter modules.
// Assumes gcc_map.svh is on the include path.
`include "gcc_map.svh"

package gcc_pkg;
   // Pin selector, counts and destination tags
   typedef logic [`GCC_SEL_W-1:0]   gcc_sel_t;
   typedef logic [`GCC_CNT_W-1:0]   gcc_count_t;
   typedef logic [`GCC_DEST_W-1:0]  gcc_dest_t;
   typedef logic [`GCC_PIN_NUM-1:0] gcc_pins_t;
   // Control sequence
   typedef enum logic [1:0] {GCC_IDLE, GCC_SETUP, GCC_RUN} gcc_state_t;
endpackage

// >>> logic/gcc_edge_if.sv
// Link between the window control and the cycle detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none

interface gcc_edge_if;
   logic level;   // Synchronised level of the selected pin
   logic arm;     // Capture reference level
   logic run;     // Window open
   logic cycle;   // One full cycle seen, one-cycle pulse

   // Detector end
   modport det (input level, input arm, input run, output cycle);
   // Control end
   modport ctl (output level, output arm, output run, input cycle);
endinterface

`default_nettype wire

// >>> logic/gcc_cycle_det.sv
// Full-cycle detector: pulses once each time the level returns to its
// starting value after leaving it. Assumes level is already synchronised.
`timescale 1ns/1ns
`default_nettype none

module gcc_cycle_det (
   input  wire logic  clk_i,
   input  wire logic  rst_n_i,
   gcc_edge_if.det    edge_if
);
   import gcc_pkg::*;

   logic ref_q, ref_d;     // Level at window start
   logic prev_q, prev_d;   // Level one cycle ago
   logic cyc_q, cyc_d;     // Registered cycle pulse

   // ==========================================
   // Next values
   always_comb begin
      ref_d  = ref_q;
      prev_d = edge_if.level;
      cyc_d  = 1'b0;
      if (edge_if.arm) begin
         // Reference taken, nothing counted yet
         ref_d = edge_if.level;
      end else if (edge_if.run) begin
         // Return to the reference level closes one cycle
         cyc_d = (prev_q != ref_q) && (edge_if.level == ref_q);
      end
   end

   // Registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_q  <= 1'b0;
         prev_q <= 1'b0;
         cyc_q  <= 1'b0;
      end else begin
         ref_q  <= ref_d;
         prev_q <= prev_d;
         cyc_q  <= cyc_d;
      end
   end

   assign edge_if.cycle = cyc_q;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_cycle_return: assert property (
      edge_if.cycle |-> $past(edge_if.level) == ref_q && $past(prev_q) != ref_q)
      else $error("cycle pulse without return to reference level");

   chk_no_edge_count: assert property (
      edge_if.run && !edge_if.arm && prev_q == ref_q && edge_if.level == ref_q
      |=> !edge_if.cycle)
      else $error("cycle counted while level stayed at reference");
endmodule

`default_nettype wire

// >>> logic/gcc_counter.sv
// Gated cycle counter top: selects a pin, makes it an input, counts
// full cycles for a programmed number of time units, then hands over
// the total with its destination tag. Assumes pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "gcc_map.svh"

// Operation
// - Selected pin made input for whole window
// - Pin selector zero through fifteen
// - Window lasts one to 65535 time units
// - Count full cycles, not single edges
// - Detect levels of minimum pulse width
// - Count square wave up to maximum frequency
// - Write total to named destination at end
module gcc_counter #(
   parameter int UNIT_CYCLES = `GCC_UNIT_CYC  // Clock cycles per time unit
) (
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   input  wire logic          start_i,       // Request, one-cycle pulse
   input  wire gcc_pkg::gcc_sel_t   pin_sel_i,     // Pin to observe
   input  wire gcc_pkg::gcc_count_t duration_i,    // Window in time units
   input  wire gcc_pkg::gcc_dest_t  dest_i,        // Result destination tag
   input  wire logic          dir_load_i,    // Load pin directions
   input  wire gcc_pkg::gcc_pins_t  dir_value_i,   // 1 = output
   input  wire gcc_pkg::gcc_pins_t  pin_i,         // Pin levels
   output logic               busy_o,        // Request in progress
   output logic               done_o,        // Result write strobe
   output gcc_pkg::gcc_count_t      result_o,      // Cycle total
   output gcc_pkg::gcc_dest_t       result_dest_o, // Where total goes
   output gcc_pkg::gcc_pins_t       pin_oe_o       // Pin output enables
);
   import gcc_pkg::*;

   localparam int PRE_W = $clog2(UNIT_CYCLES + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);

   // ==========================================
   // Pin synchroniser
   gcc_pins_t sync1_q, sync2_q;   // Two-stage capture of all pins

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= `GCC_PIN_ZERO;
         sync2_q <= `GCC_PIN_ZERO;
      end else begin
         // Sampled every clock, far below the minimum pulse width
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
      end
   end

   // ==========================================
   // Control state
   gcc_state_t state_q, state_d;     // Sequence
   gcc_sel_t   sel_q, sel_d;         // Latched selector
   gcc_count_t dur_q, dur_d;         // Latched window length
   gcc_dest_t  dest_q, dest_d;       // Latched destination
   gcc_count_t units_q, units_d;     // Elapsed time units
   logic [PRE_W-1:0] pre_q, pre_d;   // Time-unit divider
   gcc_count_t acc_q, acc_d;         // Cycle accumulator
   gcc_count_t res_q, res_d;         // Result register
   logic       done_q, done_d;       // Done strobe
   logic       busy_q, busy_d;       // Busy flag
   gcc_pins_t  oe_q, oe_d;           // Pin directions
   logic       tick;                 // One time unit elapsed
   logic       last;                 // Final unit of window
   logic       accept;               // Request taken

   gcc_edge_if edge_if ();

   // Detector inputs
   assign edge_if.level = sync2_q[sel_q];
   assign edge_if.arm   = (state_q == GCC_SETUP);
   assign edge_if.run   = (state_q == GCC_RUN);

   gcc_cycle_det i_gcc_cycle_det (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .edge_if (edge_if)
   );

   // Divider enable and window end
   assign tick   = (state_q == GCC_RUN) && (pre_q == PRE_LAST);
   assign last   = tick && (units_q == dur_q - `GCC_CNT_ONE);
   assign accept = start_i && (state_q == GCC_IDLE) && (duration_i != `GCC_CNT_ZERO);

   // Next values
   always_comb begin
      state_d = state_q;
      sel_d   = sel_q;
      dur_d   = dur_q;
      dest_d  = dest_q;
      units_d = units_q;
      pre_d   = pre_q;
      acc_d   = acc_q;
      res_d   = res_q;
      done_d  = 1'b0;
      busy_d  = busy_q;
      oe_d    = oe_q;
      unique case (state_q)
         GCC_IDLE: begin
            // Direction loads only between requests
            if (dir_load_i) begin
               oe_d = dir_value_i;
            end
            if (accept) begin
               sel_d         = pin_sel_i;
               dur_d         = duration_i;
               dest_d        = dest_i;
               oe_d[pin_sel_i] = 1'b0;
               acc_d         = `GCC_CNT_ZERO;
               units_d       = `GCC_CNT_ZERO;
               pre_d         = '0;
               busy_d        = 1'b1;
               state_d       = GCC_SETUP;
            end
         end
         GCC_SETUP: begin
            // Reference level captured, window opens
            state_d = GCC_RUN;
         end
         GCC_RUN: begin
            // Every cycle pulse arriving while running counts, saturating; one detected in the final clock arrives after the window
            if (edge_if.cycle && acc_q != `GCC_CNT_MAX) begin
               acc_d = acc_q + `GCC_CNT_ONE;
            end
            pre_d = tick ? '0 : pre_q + PRE_W'(1);
            if (tick) begin
               units_d = units_q + `GCC_CNT_ONE;
            end
            if (last) begin
               res_d   = acc_d;
               done_d  = 1'b1;
               busy_d  = 1'b0;
               state_d = GCC_IDLE;
            end
         end
      endcase
   end

   // Registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= GCC_IDLE;
         sel_q   <= '0;
         dur_q   <= `GCC_CNT_ZERO;
         dest_q  <= '0;
         units_q <= `GCC_CNT_ZERO;
         pre_q   <= '0;
         acc_q   <= `GCC_CNT_ZERO;
         res_q   <= `GCC_CNT_ZERO;
         done_q  <= 1'b0;
         busy_q  <= 1'b0;
         oe_q    <= `GCC_PIN_ZERO;
      end else begin
         state_q <= state_d;
         sel_q   <= sel_d;
         dur_q   <= dur_d;
         dest_q  <= dest_d;
         units_q <= units_d;
         pre_q   <= pre_d;
         acc_q   <= acc_d;
         res_q   <= res_d;
         done_q  <= done_d;
         busy_q  <= busy_d;
         oe_q    <= oe_d;
      end
   end

   // Outputs straight from flops
   assign busy_o        = busy_q;
   assign done_o        = done_q;
   assign result_o      = res_q;
   assign result_dest_o = dest_q;
   assign pin_oe_o      = oe_q;

   // ==========================================
   // Checks
   logic [31:0] win_q;   // Clocks spent in the open window

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win_q <= 32'h0000_0000;
      end else begin
         win_q <= (state_q == GCC_RUN) ? win_q + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_pin_input: assert property (busy_o |-> !pin_oe_o[sel_q])
      else $error("selected pin driven during window");

   chk_sel_latched: assert property (
      accept |=> sel_q == $past(pin_sel_i) && busy_o)
      else $error("selector not latched on start");

   chk_window_len: assert property (
      done_o |-> win_q == 32'(dur_q) * 32'(UNIT_CYCLES))
      else $error("window length wrong");

   // Held off until both stages have left reset, else stale pins mismatch
   chk_sync_delay: assert property (
      $past(rst_n_i) && $past(rst_n_i, 2) |-> $past(pin_i, 2) == sync2_q)
      else $error("pin sampling delay not two clocks");

   chk_acc_step: assert property (
      state_q == GCC_RUN && edge_if.cycle && acc_q != `GCC_CNT_MAX && !last
      |=> acc_q == $past(acc_q) + `GCC_CNT_ONE)
      else $error("cycle pulse lost");

   chk_result_write: assert property (
      last |=> done_o && result_o == $past(acc_d) && result_dest_o == $past(dest_q))
      else $error("result not written at window end");

   chk_acc_clear: assert property (accept |=> acc_q == `GCC_CNT_ZERO)
      else $error("accumulator not cleared on start");

   // Busy is low in the strobe cycle; a new request may follow at once
   chk_done_pulse: assert property (done_o |-> !busy_o ##1 !done_o)
      else $error("done strobe longer than one cycle");

   cov_done_nonzero: cover property (done_o && result_o != `GCC_CNT_ZERO);
   cov_saturate: cover property (done_o && result_o == `GCC_CNT_MAX);
   cov_start_busy: cover property (start_i && busy_o);
endmodule

`default_nettype wire

// >>> bench/gcc_wave_src.sv
// Far-side model: a digital waveform source on the sixteen pins.
// Assumes the bench calls emit() just after a rising edge of clk_i.
`timescale 1ns/1ns
`default_nettype none

module gcc_wave_src (
   input  wire logic                clk_i,  // System clock
   input  wire gcc_pkg::gcc_sel_t   sel_i,  // Pin that carries the waveform
   output gcc_pkg::gcc_pins_t       pins_o  // Pin levels seen by the device
);
   import gcc_pkg::*;

   logic sel_level = 1'h0;  // Level of the waveform pin, idles low
   logic noise_q   = 1'h0;  // Pattern on every other pin

   // ==========================================
   // Unused pins toggle every clock, so they never look quiet
   always @(posedge clk_i) begin
      noise_q <= ~noise_q;
   end

   // Waveform on the chosen pin, noise elsewhere
   always_comb begin
      pins_o = {16{noise_q}};
      pins_o[sel_i] = sel_level;
   end

   // Full low-high-low pulses, each phase held h clocks, never shorter
   task automatic emit(input int n, input int h);
      repeat (n) begin
         sel_level <= 1'h1;
         repeat (h) @(posedge clk_i);
         sel_level <= 1'h0;
         repeat (h) @(posedge clk_i);
      end
   endtask
endmodule

`default_nettype wire

// >>> bench/gcc_counter_bench.sv
// Self-checking bench of the gated cycle counter with a waveform source.
// Assumes a short time unit of four clocks for simulation.
`timescale 1ns/1ns
`default_nettype none

module gcc_counter_bench;
   import gcc_pkg::*;

   // ==========================================
   // Signals
   localparam int U = 4;          // Clocks per time unit
   logic        clk_i       = 1'h0;
   logic        rst_n_i     = 1'h0;
   logic        start_i     = 1'h0;
   gcc_sel_t    pin_sel_i   = 4'h0;
   gcc_count_t  duration_i  = 16'h0000;
   gcc_dest_t   dest_i      = 8'h00;
   logic        dir_load_i  = 1'h0;
   gcc_pins_t   dir_value_i = 16'h0000;
   gcc_pins_t   pin_i;
   logic        busy_o;
   logic        done_o;
   gcc_count_t  result_o;
   gcc_dest_t   result_dest_o;
   gcc_pins_t   pin_oe_o;
   int          fails       = 0;
   int          comparisons = 0;

   // Clock, 10 ns period
   always #5 clk_i = ~clk_i;

   gcc_counter #(.UNIT_CYCLES(U)) i_gcc_counter (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .pin_sel_i(pin_sel_i),
      .duration_i(duration_i), .dest_i(dest_i), .dir_load_i(dir_load_i),
      .dir_value_i(dir_value_i), .pin_i(pin_i), .busy_o(busy_o), .done_o(done_o),
      .result_o(result_o), .result_dest_o(result_dest_o), .pin_oe_o(pin_oe_o));

   gcc_wave_src i_gcc_wave_src (.clk_i(clk_i), .sel_i(pin_sel_i), .pins_o(pin_i));

   // ==========================================
   // Comparison and verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================
   // One counting request with n pulses of h clocks a phase
   // Poke: a second request and a direction load arrive while busy,
   // and both must be ignored
   task automatic run(input int sel, input int dur, input int dst, input int n,
                      input int h, input bit poke);
      int k;
      k = 0;
      pin_sel_i  <= 4'(sel);
      duration_i <= 16'(dur);
      dest_i     <= 8'(dst);
      start_i    <= 1'h1;
      @(posedge clk_i);
      start_i <= 1'h0;
      fork
         begin
            repeat (2) @(posedge clk_i);
            i_gcc_wave_src.emit(n, h);
         end
         do begin
            @(posedge clk_i);
            #1;
            k++;
            if (poke && k == 3) begin
               dest_i      <= 8'hc3;
               start_i     <= 1'h1;
               dir_value_i <= 16'h0000;
               dir_load_i  <= 1'h1;
            end
            if (poke && k == 4) begin
               start_i    <= 1'h0;
               dir_load_i <= 1'h0;
            end
            if (done_o !== 1'h1) begin
               check(32'(pin_oe_o[sel]), 32'h0000_0000);
               check(32'(busy_o), 32'h0000_0001);
            end
         end while (done_o !== 1'h1 && k < dur * U + 12);
      join
      if (done_o !== 1'h1) begin
         fails++;
         tally_and_finish();
      end
      check(32'(k), 32'(1 + dur * U));
      check(32'(result_o), 32'(n));
      check(32'(result_dest_o), 32'(dst));
   endtask

   // Quiet period: no strobe, no busy
   task automatic quiet(input int cycles);
      repeat (cycles) begin
         @(posedge clk_i);
         #1;
         check(32'(done_o | busy_o), 32'h0000_0000);
      end
   endtask

   // Zero duration is refused
   task automatic refused();
      duration_i <= 16'h0000;
      start_i    <= 1'h1;
      @(posedge clk_i);
      start_i <= 1'h0;
      quiet(12);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'h1;
      @(posedge clk_i);
      #1;
      check(32'(pin_oe_o), 32'h0000_0000);
      check(32'({busy_o, done_o, result_o, result_dest_o}), 32'h0000_0000);
      @(posedge clk_i);
      dir_value_i <= 16'hffff;
      dir_load_i  <= 1'h1;
      @(posedge clk_i);
      dir_load_i <= 1'h0;
      @(posedge clk_i);
      // Fastest wave: three clocks a phase
      run(0, 8, 8'h11, 3, 3, 1'b0);
      // Back to back from the strobe cycle, shortest window, cleared total
      run(15, 1, 8'h22, 0, 3, 1'b0);
      @(posedge clk_i);
      run(7, 20, 8'h33, 5, 6, 1'b1);
      quiet(12);
      check(32'(pin_oe_o), 32'h0000_7f7e);
      @(posedge clk_i);
      refused();
      tally_and_finish();
   end
endmodule

`default_nettype wire
